// >>> shared/hpse_pkg.sv
// hotplug serr/irq status block: offsets, field positions, reset values
// assumes a byte-addressed apb window of 256 bytes, 32-bit data
package hpse_pkg;

  localparam int NSLOT   = 6;   // logical slot registers
  localparam int LATCH_W = 5;   // implemented slot event latch bits
  localparam int IRQ_W   = 3;   // interrupt status/mask width

  // register byte offsets
  localparam logic [7:0] CMD_OFS   = 8'h14;
  localparam logic [7:0] LOC_OFS   = 8'h1C;
  localparam logic [7:0] CTRL_OFS  = 8'h20;
  localparam logic [7:0] SLOT_OFS  = 8'h24;
  localparam logic [7:0] ISTAT_OFS = 8'h44;
  localparam logic [7:0] IMASK_OFS = 8'h48;

  // controller_error_irq_enable fields
  localparam int ATD_BIT  = 17;
  localparam int CCD_BIT  = 16;
  localparam int ASM_BIT  = 3;
  localparam int COMMAND_DONE_IRQ_MASK_BIT = 2;
  localparam int GSM_BIT  = 1;
  localparam int GIM_BIT  = 0;

  // controller command register fields
  localparam int BUSY_BIT = 16;

  // logical slot register fields
  localparam int SMASK_LSB = 24;
  localparam int LATCH_LSB = 16;
  localparam int SLOT_PFLT = 4;   // connected power fault latch bit
  localparam int SLOT_MRL  = 3;   // mrl change latch bit
  localparam int SMASK_PFLT = 7;  // serr mask of power fault
  localparam int SMASK_MRL  = 6;  // serr mask of mrl change

  // interrupt status bits
  localparam int IRQ_CMD  = 0;
  localparam int IRQ_ARB  = 1;
  localparam int IRQ_SLOT = 2;

  // reset values
  localparam logic [3:0]       CTRL_MASK_RST = 4'hF;
  localparam logic [7:0]       SLOT_MASK_RST = 8'hFF;
  localparam logic [IRQ_W-1:0] IMASK_RST     = 3'h7;

  // a slot has serr pending while an unmasked serr-capable latch bit is set
  function automatic logic slot_serr(input logic [LATCH_W-1:0] lat,
                                     input logic [7:0]         msk);
    return (lat[SLOT_PFLT] & ~msk[SMASK_PFLT]) |
           (lat[SLOT_MRL] & ~msk[SMASK_MRL]);
  endfunction : slot_serr

endpackage : hpse_pkg

// >>> shared/hpse_flag_if.sv
// set/clear/flag bundle between the top and a sticky flag bank
// assumes one clock; set and clear are single-cycle terms
`timescale 1ns/1ps
`default_nettype none
interface hpse_flag_if #(parameter int W = 1);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;
  modport owner (input set, input clr, output flags);
  modport user  (output set, output clr, input flags);
endinterface : hpse_flag_if
`default_nettype wire

// >>> hdl/hpse_w1c.sv
// bank of write-one-to-clear sticky flags
// assumes clr comes from a bus write strobe gated by the written ones
`timescale 1ns/1ps
`default_nettype none
module hpse_w1c #(
  parameter int W = 1
) (
  input wire logic    pclk,
  input wire logic    presetn,
  hpse_flag_if.owner  f
);
  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    flags_d = (flags_q & ~f.clr) | f.set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign f.flags = flags_q;

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (|f.set) |=> ((flags_q & $past(f.set)) == $past(f.set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("sticky flag lost an event");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
    (f.clr == '0) |=> ((flags_q & $past(flags_q)) == $past(flags_q));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("flag dropped without a clear");
endmodule : hpse_w1c
`default_nettype wire

// >>> hdl/hpse_busy.sv
// controller busy tracker: rises on an accepted command, falls on finish
// assumes finish is a one-cycle pulse from the command engine
`timescale 1ns/1ps
`default_nettype none
module hpse_busy (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  start,
  input wire logic  finish,
  output var logic  busy,
  output var logic  done
);
  logic busy_q;
  logic busy_d;

  // a new command is refused while one is running
  always_comb begin
    busy_d = busy_q;
    if (busy_q && finish) begin
      busy_d = 1'b0;
    end else if (!busy_q && start) begin
      busy_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
  assign done = busy_q & finish;

  property p_busy_hold;
    @(posedge pclk) disable iff (!presetn)
    (busy_q && !finish) |=> busy_q;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy fell without finish");
endmodule : hpse_busy
`default_nettype wire

// >>> hdl/hpse_top.sv
// hotplug controller serr locator, error/irq enable and slot registers
// assumes apb3 master on pclk; event and status inputs come from logic
// on the same clock, so none of them is synchronised here
//
// Function
// - unmasked serr-capable slot event sets slot pending
// - several slot pending bits may be set
// - pending clears once serr-capable latches clear
// - arbiter pending is timeout flag and not mask
// - locator read-only, reset zero, upper bits zero
// - arbiter timeout sets flag, write one clears
// - busy falling sets command done flag
// - arbiter mask blocks serr, not the flag
// - unmasked arbiter timeout sends nonfatal message
// - command irq mask keeps the done flag
// - global serr mask blocks all serr
// - global irq mask blocks irq, not locators
// - wakeup ignores the global irq mask
// - enable register resets to 0000000F
// - six slot registers from 24h, three fields
// - busy rises on command, falls on finish
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module hpse_top (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  output var logic [31:0]           prdata,
  output var logic                  pready,
  output var logic                  pslverr,
  input wire logic                  arb_timeout,
  input wire logic                  cmd_finish,
  input wire logic                  serr_enable,
  input wire logic                  nonfatal_enable,
  input wire logic [29:0]           slot_event,
  input wire logic [95:0]           slot_status,
  output var logic                  cmd_start,
  output var logic [7:0]            cmd_code,
  output var logic                  irq,
  output var logic                  err_nonfatal,
  output var logic                  wakeup
);
  localparam int NS = hpse_pkg::NSLOT;
  localparam int LW = hpse_pkg::LATCH_W;
  localparam int IW = hpse_pkg::IRQ_W;

  // bus state
  logic [31:0]  prdata_q, prdata_d;
  logic         pready_q, pready_d;
  logic         pslverr_q, pslverr_d;
  // software-written state
  logic [3:0]   cmask_q, cmask_d;
  logic [7:0]   smask_q [NS];
  logic [7:0]   smask_d [NS];
  logic [IW-1:0] imask_q, imask_d;
  logic [7:0]   code_q, code_d;
  logic         start_q, start_d;
  // derived state
  logic [7:0]   loc_q, loc_d;
  logic         irq_q, irq_d;
  logic         err_q, err_d;
  logic         wake_q, wake_d;

  logic         setup, wr, cmd_wr;
  logic         busy, cmd_done;
  logic         arbiter_timeout_flag, ccd;
  logic [31:0]  rd_val;
  logic         rd_hit;
  logic [LW-1:0] latch [NS];
  logic [NS-1:0] slot_pend, slot_live, slot_irq_ev;

  // true when the address selects logical slot register n
  function automatic logic slot_sel(input logic [7:0] a, input int n);
    return a == 8'(32'(hpse_pkg::SLOT_OFS) + 4 * n);
  endfunction : slot_sel

  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pready_q & pwrite;
  assign cmd_wr = wr & (paddr == hpse_pkg::CMD_OFS);

  // sticky flag banks
  hpse_flag_if #(.W(2))  ctrl_if ();
  hpse_flag_if #(.W(IW)) irq_if ();
  hpse_flag_if #(.W(LW)) slot_if [NS] ();

  hpse_w1c #(.W(2)) u_ctrl_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (ctrl_if)
  );

  hpse_w1c #(.W(IW)) u_irq_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (irq_if)
  );

  hpse_busy u_busy (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cmd_wr),
    .finish  (cmd_finish),
    .busy    (busy),
    .done    (cmd_done)
  );

  // controller event flags: bit 1 arbiter timeout, bit 0 command done
  assign ctrl_if.set = {arb_timeout, cmd_done};
  assign ctrl_if.clr = (wr && paddr == hpse_pkg::CTRL_OFS) ?
                       pwdata[hpse_pkg::ATD_BIT:hpse_pkg::CCD_BIT] :
                       2'h0;
  assign arbiter_timeout_flag = ctrl_if.flags[1];
  assign ccd = ctrl_if.flags[0];

  // one latch bank per slot; pending bits are independent per slot
  genvar n;
  generate
    for (n = 0; n < NS; n++) begin : g_slot
      hpse_w1c #(.W(LW)) u_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (slot_if[n])
      );
      assign slot_if[n].set = slot_event[n*LW +: LW];
      assign slot_if[n].clr = (wr && slot_sel(paddr, n)) ?
                              pwdata[hpse_pkg::LATCH_LSB +: LW] :
                              {LW{1'b0}};
      assign latch[n] = slot_if[n].flags;
      assign slot_pend[n] = hpse_pkg::slot_serr(latch[n],
                                                smask_q[n]);
      assign slot_live[n] = |latch[n];
      assign slot_irq_ev[n] = |(slot_event[n*LW +: LW] &
                                ~smask_q[n][LW-1:0]);
    end
  endgenerate

  // interrupt events; masked slot events never reach the status
  assign irq_if.set = {|slot_irq_ev, arb_timeout, cmd_done};
  assign irq_if.clr = (wr && paddr == hpse_pkg::ISTAT_OFS) ?
                      pwdata[IW-1:0] : {IW{1'b0}};

  // read decode; unmapped addresses answer zero with pslverr
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (paddr)
      hpse_pkg::CMD_OFS: begin
        rd_val[7:0] = code_q;
        rd_val[hpse_pkg::BUSY_BIT] = busy;
      end
      hpse_pkg::LOC_OFS: begin
        rd_val[7:0] = loc_q;
      end
      hpse_pkg::CTRL_OFS: begin
        rd_val[hpse_pkg::ATD_BIT] = arbiter_timeout_flag;
        rd_val[hpse_pkg::CCD_BIT] = ccd;
        rd_val[3:0] = cmask_q;
      end
      hpse_pkg::ISTAT_OFS: begin
        rd_val[IW-1:0] = irq_if.flags;
      end
      hpse_pkg::IMASK_OFS: begin
        rd_val[IW-1:0] = imask_q;
      end
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < NS; i++) begin
          if (slot_sel(paddr, i)) begin
            rd_hit = 1'b1;
            rd_val[31:24] = smask_q[i];
            rd_val[hpse_pkg::LATCH_LSB +: LW] = latch[i];
            rd_val[15:0] = slot_status[i*16 +: 16];
          end
        end
      end
    endcase
  end

  // apb answer: pready rises in the first access cycle, zero wait
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup & ~rd_hit;
    prdata_d  = prdata_q;
    if (setup) begin
      prdata_d = pwrite ? 32'h0 : rd_val;
    end
  end

  // software-written fields; writes land at the access edge
  always_comb begin
    cmask_d = cmask_q;
    imask_d = imask_q;
    code_d  = code_q;
    start_d = 1'b0;
    for (int i = 0; i < NS; i++) begin
      smask_d[i] = smask_q[i];
      if (wr && slot_sel(paddr, i)) begin
        smask_d[i] = pwdata[hpse_pkg::SMASK_LSB +: 8];
      end
    end
    if (wr && paddr == hpse_pkg::CTRL_OFS) begin
      cmask_d = pwdata[3:0];
    end
    if (wr && paddr == hpse_pkg::IMASK_OFS) begin
      imask_d = pwdata[IW-1:0];
    end
    // a command written while busy is dropped, as the engine expects
    if (cmd_wr && !busy) begin
      code_d  = pwdata[7:0];
      start_d = 1'b1;
    end
  end

  // locator, interrupt, error message and wakeup
  always_comb begin
    loc_d = {1'b0, slot_pend, arbiter_timeout_flag & ~cmask_q[hpse_pkg::ASM_BIT]};
    irq_d = ~cmask_q[hpse_pkg::GIM_BIT] &
            |(irq_if.flags & ~imask_q &
              {2'h3, ~cmask_q[hpse_pkg::COMMAND_DONE_IRQ_MASK_BIT]});
    // message on a new arbiter timeout or a newly pending slot
    err_d = ~cmask_q[hpse_pkg::GSM_BIT] &
            (serr_enable | nonfatal_enable) &
            ((arb_timeout & ~cmask_q[hpse_pkg::ASM_BIT]) |
             (|(slot_pend & ~loc_q[6:1])));
    wake_d = |slot_live;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      cmask_q   <= hpse_pkg::CTRL_MASK_RST;
      imask_q   <= hpse_pkg::IMASK_RST;
      code_q    <= 8'h0;
      start_q   <= 1'b0;
      for (int i = 0; i < NS; i++) begin
        smask_q[i] <= hpse_pkg::SLOT_MASK_RST;
      end
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      cmask_q   <= cmask_d;
      imask_q   <= imask_d;
      code_q    <= code_d;
      start_q   <= start_d;
      for (int i = 0; i < NS; i++) begin
        smask_q[i] <= smask_d[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_q  <= 8'h0;
      irq_q  <= 1'b0;
      err_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      loc_q  <= loc_d;
      irq_q  <= irq_d;
      err_q  <= err_d;
      wake_q <= wake_d;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign cmd_start    = start_q;
  assign cmd_code     = code_q;
  assign irq          = irq_q;
  assign err_nonfatal = err_q;
  assign wakeup       = wake_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_asp;
    (arbiter_timeout_flag && !cmask_q[hpse_pkg::ASM_BIT]) |=> loc_q[0];
  endproperty
  a_asp: assert property (p_asp)
    else $error("arbiter pending not shown");

  property p_ccd;
    (busy && cmd_finish) |=> (!busy && ccd);
  endproperty
  a_ccd: assert property (p_ccd)
    else $error("command done flag not set on busy fall");

  property p_atd_set;
    arb_timeout |=> arbiter_timeout_flag;
  endproperty
  a_atd_set: assert property (p_atd_set)
    else $error("arbiter timeout flag not set");

  property p_err;
    (arb_timeout && cmask_q[3:1] == 3'h0 &&
     (serr_enable || nonfatal_enable)) |=> err_nonfatal;
  endproperty
  a_err: assert property (p_err)
    else $error("nonfatal message missing");

  property p_gsm;
    cmask_q[hpse_pkg::GSM_BIT] |=> !err_nonfatal;
  endproperty
  a_gsm: assert property (p_gsm)
    else $error("serr sent under global serr mask");

  property p_gim;
    cmask_q[hpse_pkg::GIM_BIT] |=> !irq;
  endproperty
  a_gim: assert property (p_gim)
    else $error("irq raised under global irq mask");

  property p_slot_pend;
    (latch[0][hpse_pkg::SLOT_PFLT] && !smask_q[0][hpse_pkg::SMASK_PFLT])
      |=> loc_q[1];
  endproperty
  a_slot_pend: assert property (p_slot_pend)
    else $error("slot pending not set");

  // slot status is read through; the word answers in the access cycle
  property p_slot_read;
    (setup && !pwrite && paddr == hpse_pkg::SLOT_OFS)
      |=> (pready && prdata[15:0] == $past(slot_status[15:0]));
  endproperty
  a_slot_read: assert property (p_slot_read)
    else $error("slot status read wrong or late");

  property p_loc_read;
    (setup && !pwrite && paddr == hpse_pkg::LOC_OFS)
      |=> (prdata == {24'h0, $past(loc_q)});
  endproperty
  a_loc_read: assert property (p_loc_read)
    else $error("locator read value wrong");

  property p_slot_clr;
    (latch[0][hpse_pkg::SLOT_PFLT:hpse_pkg::SLOT_MRL] == 2'h0)
      |=> !loc_q[1];
  endproperty
  a_slot_clr: assert property (p_slot_clr)
    else $error("slot pending kept after latches cleared");

  // wakeup must not depend on the global irq mask
  property p_wake;
    (cmask_q[hpse_pkg::GIM_BIT] && |latch[0]) |=> wakeup;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wakeup blocked by global irq mask");
endmodule : hpse_top
`default_nettype wire

// >>> tb/hpse_up_model.sv
// upstream port model: takes nonfatal error message requests
// assumes err_nonfatal is a one-cycle pulse on pclk per message
`timescale 1ns/1ps
`default_nettype none
module hpse_up_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic err_nonfatal,
  output var int   msg_count
);
  // count every message; a held request would count twice, so it shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_count <= 0;
    end else if (err_nonfatal) begin
      msg_count <= msg_count + 1;
    end
  end
endmodule : hpse_up_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the hotplug serr/irq status block
// assumes zero-wait apb slave on pclk and registered event outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        arb_timeout = 0;
  logic        cmd_finish = 0;
  logic        serr_enable = 0;
  logic        nonfatal_enable = 0;
  logic [29:0] slot_event = '0;
  logic [95:0] slot_status;
  logic        cmd_start;
  logic [7:0]  cmd_code;
  logic        irq;
  logic        err_nonfatal;
  logic        wakeup;
  int          msgs;
  int          miscompares = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          starts = 0;

  hpse_top hpse_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arb_timeout(arb_timeout), .cmd_finish(cmd_finish),
    .serr_enable(serr_enable), .nonfatal_enable(nonfatal_enable),
    .slot_event(slot_event), .slot_status(slot_status),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .irq(irq),
    .err_nonfatal(err_nonfatal), .wakeup(wakeup));
  hpse_up_model hpse_up_model_inst (.pclk(pclk), .presetn(presetn),
    .err_nonfatal(err_nonfatal), .msg_count(msgs));

  // slot n status reads back as 1230h + n
  always_comb begin
    for (int n = 0; n < 6; n++) begin
      slot_status[n*16 +: 16] = 16'h1230 + 16'(n);
    end
  end

  always #2 pclk = ~pclk;

  // count accepted commands; a refused write must not pulse
  always @(posedge pclk) begin
    if (cmd_start === 1'b1) begin
      starts++;
    end
  end

  // hang guard: whole run needs well under 3000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict;
    end
  end

  task print_verdict;
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    check_count++;
    if (g !== ex) begin
      $display("Error %s exp %h got %h", nm, ex, g);
      miscompares++;
    end
  endtask : chk

  // one apb transfer; ev raises an arbiter timeout on the write edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic ev, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    arb_timeout <= ev;
    // wait as long as the slave needs; only the hang guard ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    arb_timeout <= 0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, a, d, 0, r, e);
  endtask : wr

  task rc(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(0, a, 32'h0, 0, r, e);
    chk($sformatf("reg_%h", a), ex, r);
  endtask : rc

  task settle;
    repeat (3) @(posedge pclk);
  endtask : settle

  // v[0] arbiter timeout, v[1] command finish, v[31:2] slot events
  task ev(input logic [31:0] v);
    @(posedge pclk);
    arb_timeout <= v[0];
    cmd_finish <= v[1];
    slot_event <= v[31:2];
    @(posedge pclk);
    arb_timeout <= 0;
    cmd_finish <= 0;
    slot_event <= '0;
    settle;
  endtask : ev

  task s_reset;
    logic [31:0] r;
    logic        e;
    rc(8'h20, 32'h0000000F);
    rc(8'h1C, 32'h00000000);
    wr(8'h1C, 32'hFFFFFFFF);
    rc(8'h1C, 32'h00000000);
    apb(0, 8'h80, 32'h0, 0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
  endtask : s_reset

  task s_arb;
    ev(32'h00000001);
    rc(8'h20, 32'h0002000F);
    rc(8'h1C, 32'h00000000);
    chk("msgs", 0, msgs);
    wr(8'h20, 32'h00000005);
    rc(8'h20, 32'h00020005);
    rc(8'h1C, 32'h00000001);
    ev(32'h00000001);
    chk("msgs", 0, msgs);
    nonfatal_enable <= 1;
    ev(32'h00000001);
    chk("msgs", 1, msgs);
    nonfatal_enable <= 0;
    serr_enable <= 1;
    ev(32'h00000001);
    chk("msgs", 2, msgs);
    wr(8'h20, 32'h00020007);
    rc(8'h20, 32'h00000007);
    ev(32'h00000001);
    chk("msgs", 2, msgs);
    wr(8'h20, 32'h0002000F);
    rc(8'h1C, 32'h00000000);
  endtask : s_arb

  task s_race;
    logic [31:0] r;
    logic        e;
    // clear and a new timeout land on the same edge: flag must stay
    apb(1, 8'h20, 32'h0002000F, 1, r, e);
    settle;
    rc(8'h20, 32'h0002000F);
  endtask : s_race

  task s_cmd;
    wr(8'h48, 32'h00000000);
    wr(8'h20, 32'h0003000A);
    wr(8'h44, 32'h00000007);
    wr(8'h14, 32'h000000A5);
    wr(8'h14, 32'h0000005A);
    rc(8'h14, 32'h000100A5);
    chk("cmd_code", 32'hA5, {24'h0, cmd_code});
    chk("cmd_start", 1, starts);
    rc(8'h20, 32'h0000000A);
    ev(32'h00000002);
    rc(8'h14, 32'h000000A5);
    rc(8'h20, 32'h0001000A);
    chk("irq", 1, {31'h0, irq});
    wr(8'h20, 32'h0000000E);
    settle;
    chk("irq", 0, {31'h0, irq});
    rc(8'h20, 32'h0001000E);
    wr(8'h20, 32'h0000000B);
    settle;
    chk("irq", 0, {31'h0, irq});
    wr(8'h20, 32'h0000000A);
    settle;
    chk("irq", 1, {31'h0, irq});
    wr(8'h44, 32'h00000007);
    wr(8'h20, 32'h0001000F);
    settle;
    chk("irq", 0, {31'h0, irq});
  endtask : s_cmd

  task s_slot;
    wr(8'h24, 32'h7F000000);
    wr(8'h2C, 32'h7F000000);
    // power fault on slots 0, 1 and 2; slot 1 keeps its serr mask
    ev(32'h00010840);
    rc(8'h1C, 32'h0000000A);
    chk("msgs", 2, msgs);
    rc(8'h24, 32'h7F101230);
    rc(8'h38, 32'hFF001235);
    chk("wakeup", 1, {31'h0, wakeup});
    rc(8'h1C, 32'h0000000A);
    wr(8'h24, 32'h7F100000);
    settle;
    rc(8'h1C, 32'h00000008);
    wr(8'h28, 32'hFF100000);
    wr(8'h2C, 32'h7F100000);
    settle;
    rc(8'h1C, 32'h00000000);
    chk("wakeup", 0, {31'h0, wakeup});
  endtask : s_slot

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    s_reset;
    s_arb;
    s_race;
    s_cmd;
    s_slot;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
